// ---- src/pmw_pkg.sv ----
package pmw_pkg;

  // System clock and internal oscillator
  localparam int CLK_HZ = 50_000_000;
  localparam int OSC_HZ = 32_000;
  // Clock cycles per oscillator tick, rounded down
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  // Oscillator period in ns
  localparam int OSC_NS = 1_000_000_000 / OSC_HZ;

  // Host clear pulse, least time, rounded up to ticks
  localparam int CLR_US = 160;
  localparam int CLR_TICKS = (CLR_US * 1000 + OSC_NS - 1) / OSC_NS;
  // Data bit hold on the config pin, sampled after this
  localparam int HOLD_US = 80;
  localparam int HOLD_TICKS = (HOLD_US * 1000 + OSC_NS - 1) / OSC_NS;
  // Low time that latches a received word
  localparam int LOAD_US = 650;
  localparam int LOAD_TICKS = (LOAD_US * 1000 + OSC_NS - 1) / OSC_NS;
  // Half a second, the step of blind times and the unit of window steps
  localparam int HALF_S_MS = 500;
  localparam int HALF_S_TICKS = (HALF_S_MS * 1_000_000) / OSC_NS;
  // Window step is 2 s, four half seconds
  localparam int WIN_STEP_HALVES = 4;

  // Converter and config word
  localparam int ADC_W = 14;
  localparam int CFG_W = 25;
  localparam logic [13:0] ADC_LOW = 14'h01ff;
  localparam logic [13:0] ADC_HIGH = 14'h3e01;

  // Filter shifts (first order IIR per sample)
  localparam int LP_SHIFT = 2;
  localparam int HP_SHIFT_FAST = 6;
  localparam int HP_SHIFT_SLOW = 7;
  localparam int HB_FRAC = 8;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_FORCED = 2'h0,
    MODE_IRQ    = 2'h1,
    MODE_WAKE   = 2'h2,
    MODE_RSVD   = 2'h3
  } pmw_mode_type;

  // Readout source
  typedef enum logic [1:0] {
    SRC_BAND = 2'h0,
    SRC_LOW  = 2'h1,
    SRC_RSVD = 2'h2,
    SRC_TEMP = 2'h3
  } pmw_src_type;

  // Configuration word, bit 24 down to bit 0
  typedef struct packed {
    logic [7:0]   threshold;
    logic [3:0]   blind;
    logic [1:0]   pulses;
    logic [1:0]   window;
    pmw_mode_type mode;
    pmw_src_type  source;
    logic [1:0]   rsvd_hi;
    logic         hp_slow;
    logic         rsvd_lo;
    logic         count_free;
  } pmw_cfg_type;

  // Readout sample
  typedef struct packed {
    logic        valid;
    logic [13:0] data;
  } pmw_sample_type;

  // Config receiver states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_HOLD = 2'b10
  } pmw_rx_type;

endpackage

// ---- src/pmw_top.sv ----
`timescale 1ns/1ps

// How it works
// - Config is volatile, invalid until loaded
// - Config loads only through serial input
// - Link carries alarm only; sample stream goes to readout port
// - Motion always uses band-pass signal
// - Motion detection only in wake mode
// - Criteria met drives link high
// - Alarm stays high until host clears
// - Blind interval starts at every host pull-down of the alarm
// - 14-bit codes, 511 to 2^14-511 usable
// - Converter input alternates pyro and temperature when source is temperature
// - 7 Hz low-pass, 0.2/0.4 Hz high-pass
// - Timing from 32 kHz oscillator tick
// - Mode codes forced, interrupt, wake, reserved
// - Blind is 0.5 s plus value times 0.5 s
// - Alarm when pulse count reaches setting plus one
// - Pulses counted within 2 to 8 s window
module pmw_top #(
  parameter int HALF_S_TICKS = pmw_pkg::HALF_S_TICKS, // Ticks per half second
  parameter int OSC_DIV      = pmw_pkg::OSC_DIV       // Clocks per oscillator tick
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // Configuration pin
  input  wire logic                    config_serial_input,
  // Event link pin
  input  wire logic                    link_in,
  output logic                         link_out,
  output logic                         link_oe,
  // Converter
  input  wire logic [13:0]             adc_data,
  input  wire logic                    adc_valid,
  output logic                         input_selector,
  // Readout and status
  output pmw_pkg::pmw_sample_type      readout,
  output pmw_pkg::pmw_cfg_type         config_word,
  output logic                         config_valid,
  output logic                         out_of_range
);

  // Saturate a band-pass value to 14 signed bits
  function automatic logic [13:0] sat14(input logic signed [14:0] v);
    logic [13:0] r;
    r = v[13:0];
    if (v > 15'sh1fff) begin
      r = 14'h1fff;
    end else if (v < -15'sh2000) begin
      r = 14'h2000;
    end
    return r;
  endfunction

  // Oscillator tick divider
  logic [10:0] div_q;
  logic [10:0] div_d;
  logic        tick;

  // Pin synchronisers and filtered levels
  logic [2:0] ser_s_q;
  logic [2:0] ser_s_d;
  logic [2:0] lnk_s_q;
  logic [2:0] lnk_s_d;
  logic       ser_f_q;
  logic       ser_f_d;
  logic       lnk_f_q;
  logic       lnk_f_d;

  // Config receiver
  pmw_pkg::pmw_rx_type  rx_q;
  pmw_pkg::pmw_rx_type  rx_d;
  logic [4:0]           rxt_q;
  logic [4:0]           rxt_d;
  logic [24:0]          shf_q;
  logic [24:0]          shf_d;
  logic [4:0]           bits_q;
  logic [4:0]           bits_d;
  pmw_pkg::pmw_cfg_type cfg_q;
  pmw_pkg::pmw_cfg_type cfg_d;
  logic                 cval_q;
  logic                 cval_d;

  // Signal path
  logic                 sel_q;
  logic                 sel_d;
  logic [13:0]          lp_q;
  logic [13:0]          lp_d;
  logic [21:0]          hb_q;
  logic [21:0]          hb_d;
  logic [13:0]          tmp_q;
  logic [13:0]          tmp_d;
  logic                 oor_q;
  logic                 oor_d;
  pmw_pkg::pmw_sample_type ro_q;
  pmw_pkg::pmw_sample_type ro_d;
  logic signed [15:0]   lp_diff;
  logic signed [23:0]   hb_diff;
  logic signed [14:0]   band_pass_filtered;
  logic [14:0]          mag;
  logic                 pyro_in;
  logic                 in_range;

  // Motion unit
  logic [18:0] win_q;
  logic [18:0] win_d;
  logic [18:0] bld_q;
  logic [18:0] bld_d;
  logic [2:0]  pcnt_q;
  logic [2:0]  pcnt_d;
  logic        sgn_q;
  logic        sgn_d;
  logic        alm_q;
  logic        alm_d;
  logic [2:0]  clr_q;
  logic [2:0]  clr_d;
  logic        wake;
  logic        pulse;

  // Divider next value and tick
  always_comb begin
    tick  = (div_q == 11'(OSC_DIV - 1));
    div_d = tick ? 11'h000 : div_q + 11'h001;
  end

  // Three-stage synchronisers; change counts once stages agree
  always_comb begin
    ser_s_d = {ser_s_q[1:0], config_serial_input};
    lnk_s_d = {lnk_s_q[1:0], link_in};
    ser_f_d = (ser_s_q[1] == ser_s_q[2]) ? ser_s_q[2] : ser_f_q;
    lnk_f_d = (lnk_s_q[1] == lnk_s_q[2]) ? lnk_s_q[2] : lnk_f_q;
  end

  // Register divider and synchronisers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_q   <= 11'h000;
      ser_s_q <= 3'h0;
      lnk_s_q <= 3'h0;
      ser_f_q <= 1'b0;
      lnk_f_q <= 1'b0;
    end else begin
      div_q   <= div_d;
      ser_s_q <= ser_s_d;
      lnk_s_q <= lnk_s_d;
      ser_f_q <= ser_f_d;
      lnk_f_q <= lnk_f_d;
    end
  end

  // Config receiver next state
  always_comb begin
    rx_d   = rx_q;
    rxt_d  = rxt_q;
    shf_d  = shf_q;
    bits_d = bits_q;
    cfg_d  = cfg_q;
    cval_d = cval_q;
    case (rx_q)
      pmw_pkg::RX_IDLE: begin
        // Rising edge starts a bit; low time counts toward latch
        if (ser_f_d && !ser_f_q) begin
          rx_d  = pmw_pkg::RX_HOLD;
          rxt_d = 5'h00;
        end else if (ser_f_q) begin
          rxt_d = 5'h00;
        end else if (tick && rxt_q != 5'(pmw_pkg::LOAD_TICKS)) begin
          rxt_d = rxt_q + 5'h01;
          if (rxt_q == 5'(pmw_pkg::LOAD_TICKS - 1)) begin
            // Long low: take a full word, drop a partial one
            if (bits_q == 5'(pmw_pkg::CFG_W)) begin
              cfg_d  = shf_q;
              cval_d = 1'b1;
            end
            bits_d = 5'h00;
          end
        end
      end
      pmw_pkg::RX_HOLD: begin
        // Sample the data bit once the hold time has passed
        if (tick) begin
          rxt_d = rxt_q + 5'h01;
          if (rxt_q == 5'(pmw_pkg::HOLD_TICKS - 1)) begin
            shf_d = {shf_q[23:0], ser_f_q};
            if (bits_q != 5'(pmw_pkg::CFG_W)) begin
              bits_d = bits_q + 5'h01;
            end
            rxt_d = 5'h00;
            rx_d  = pmw_pkg::RX_IDLE;
          end
        end
      end
      default: begin
        rx_d = pmw_pkg::RX_IDLE;
      end
    endcase
  end

  // Register config receiver; settings zero and invalid until loaded
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_q   <= pmw_pkg::RX_IDLE;
      rxt_q  <= 5'h00;
      shf_q  <= 25'h0000000;
      bits_q <= 5'h00;
      cfg_q  <= '0;
      cval_q <= 1'b0;
    end else begin
      rx_q   <= rx_d;
      rxt_q  <= rxt_d;
      shf_q  <= shf_d;
      bits_q <= bits_d;
      cfg_q  <= cfg_d;
      cval_q <= cval_d;
    end
  end

  // Filter arithmetic and pulse detection
  always_comb begin
    in_range = (adc_data >= pmw_pkg::ADC_LOW) && (adc_data <= pmw_pkg::ADC_HIGH);
    pyro_in  = adc_valid && !sel_q;
    lp_diff  = $signed({2'b00, adc_data}) - $signed({2'b00, lp_q});
    hb_diff  = $signed({2'b00, lp_q, 8'h00}) - $signed({2'b00, hb_q});
    // Band-pass is low-pass minus its slow baseline
    band_pass_filtered      = $signed({1'b0, lp_q}) - $signed({1'b0, hb_q[21:8]});
    mag      = band_pass_filtered[14] ? 15'(-band_pass_filtered) : 15'(band_pass_filtered);
    wake     = cval_q && (cfg_q.mode == pmw_pkg::MODE_WAKE);
    // Either polarity above threshold is one pulse
    pulse    = pyro_in && in_range && (mag > {7'h00, cfg_q.threshold});
  end

  // Signal path next values
  always_comb begin
    sel_d = sel_q;
    lp_d  = lp_q;
    hb_d  = hb_q;
    tmp_d = tmp_q;
    oor_d = oor_q;
    ro_d  = '0;
    // Alternate inputs only when the source is temperature
    if (adc_valid) begin
      sel_d = (cfg_q.source == pmw_pkg::SRC_TEMP) ? !sel_q : 1'b0;
    end
    if (adc_valid && sel_q) begin
      tmp_d = adc_data;
    end
    if (pyro_in && !in_range) begin
      oor_d = 1'b1;
    end else if (pyro_in) begin
      lp_d = 14'($signed({2'b00, lp_q}) + (lp_diff >>> pmw_pkg::LP_SHIFT));
      if (cfg_q.hp_slow) begin
        hb_d = 22'($signed({2'b00, hb_q}) + (hb_diff >>> pmw_pkg::HP_SHIFT_SLOW));
      end else begin
        hb_d = 22'($signed({2'b00, hb_q}) + (hb_diff >>> pmw_pkg::HP_SHIFT_FAST));
      end
    end
    // Readout stream outside wake mode
    if (adc_valid && cval_q && !wake) begin
      ro_d.valid = 1'b1;
      case (cfg_q.source)
        pmw_pkg::SRC_LOW:  ro_d.data = lp_q;
        pmw_pkg::SRC_TEMP: ro_d.data = tmp_q;
        default:           ro_d.data = sat14(band_pass_filtered);
      endcase
      if (in_range || sel_q) begin
        oor_d = 1'b0;
      end
    end
  end

  // Register signal path
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sel_q <= 1'b0;
      lp_q  <= 14'h2000;
      hb_q  <= 22'h200000;
      tmp_q <= 14'h0000;
      oor_q <= 1'b0;
      ro_q  <= '0;
    end else begin
      sel_q <= sel_d;
      lp_q  <= lp_d;
      hb_q  <= hb_d;
      tmp_q <= tmp_d;
      oor_q <= oor_d;
      ro_q  <= ro_d;
    end
  end

  // Motion unit next values
  always_comb begin
    win_d  = win_q;
    bld_d  = bld_q;
    pcnt_d = pcnt_q;
    sgn_d  = sgn_q;
    alm_d  = alm_q;
    clr_d  = clr_q;
    // Window expiry drops the count
    if (pcnt_q != 3'h0 && tick) begin
      if (win_q == 19'h00000) begin
        pcnt_d = 3'h0;
      end else begin
        win_d = win_q - 19'h00001;
      end
    end
    // Blind interval counts down on ticks
    if (bld_q != 19'h00000 && tick) begin
      bld_d = bld_q - 19'h00001;
    end
    // Host pull-down starts the blind interval
    if (alm_q && lnk_f_q && !lnk_f_d) begin
      bld_d = 19'((32'(cfg_q.blind) + 32'h1) * HALF_S_TICKS);
    end
    // Low held long enough clears the alarm
    if (alm_q && !lnk_f_q) begin
      if (tick) begin
        clr_d = clr_q + 3'h1;
        if (clr_q == 3'(pmw_pkg::CLR_TICKS - 1)) begin
          alm_d = 1'b0;
          clr_d = 3'h0;
        end
      end
    end else begin
      clr_d = 3'h0;
    end
    if (!wake || bld_q != 19'h00000 || alm_q) begin
      pcnt_d = 3'h0;
    end else if (pulse && (cfg_q.count_free || pcnt_q == 3'h0 || band_pass_filtered[14] != sgn_q)) begin
      sgn_d  = band_pass_filtered[14];
      pcnt_d = pcnt_q + 3'h1;
      if (pcnt_q == 3'h0) begin
        win_d = 19'((32'(cfg_q.window) + 32'h1) * pmw_pkg::WIN_STEP_HALVES * HALF_S_TICKS);
      end
      if (pcnt_q == {1'b0, cfg_q.pulses}) begin
        alm_d  = 1'b1;
        pcnt_d = 3'h0;
      end
    end
  end

  // Register motion unit; alarm held until cleared
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      win_q  <= 19'h00000;
      bld_q  <= 19'h00000;
      pcnt_q <= 3'h0;
      sgn_q  <= 1'b0;
      alm_q  <= 1'b0;
      clr_q  <= 3'h0;
    end else begin
      win_q  <= win_d;
      bld_q  <= bld_d;
      pcnt_q <= pcnt_d;
      sgn_q  <= sgn_d;
      alm_q  <= alm_d;
      clr_q  <= clr_d;
    end
  end

  // Outputs
  assign link_out       = 1'b1;
  assign link_oe        = alm_q && wake;
  assign input_selector = sel_q;
  assign readout        = ro_q;
  assign config_word    = cfg_q;
  assign config_valid   = cval_q;
  assign out_of_range   = oor_q;

endmodule

// ---- sim/pmw_top_sva.sv ----
`timescale 1ns/1ps
// Checks of alarm, readout, selector and config latch at the top ports
module pmw_top_sva #(
  parameter int HALF_S_TICKS = 4,
  parameter int OSC_DIV      = pmw_pkg::OSC_DIV
) (
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    reset,
  // Pins
  input wire logic                    config_serial_input,
  input wire logic                    link_in,
  input wire logic                    link_out,
  input wire logic                    link_oe,
  // Converter
  input wire logic [13:0]             adc_data,
  input wire logic                    adc_valid,
  input wire logic                    input_selector,
  // Readout and status
  input wire pmw_pkg::pmw_sample_type readout,
  input wire pmw_pkg::pmw_cfg_type    config_word,
  input wire logic                    config_valid,
  input wire logic                    out_of_range
);
  localparam int T = OSC_DIV; // Clocks per tick
  logic [31:0] pin_low_q;  // Cycles config pin low
  logic [31:0] link_low_q; // Cycles link low
  logic [31:0] pull_q;     // Cycles since host pulled an alarm low
  logic        in_rng;     // Code inside usable span
  assign in_rng = adc_data >= pmw_pkg::ADC_LOW && adc_data <= pmw_pkg::ADC_HIGH;
  // Pull counter starts far from its bound after reset; low counters at zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_low_q <= 32'h0;
      link_low_q <= 32'h0;
      pull_q <= 32'h4000_0000;
    end else begin
      pin_low_q <= config_serial_input ? 32'h0 : pin_low_q + 32'h1;
      link_low_q <= link_in ? 32'h0 : link_low_q + 32'h1;
      pull_q <= (link_oe && !link_in && link_low_q == 32'h0) ? 32'h0 : pull_q + 32'h1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  a_oe_wake_only: assert property (
    link_oe |-> config_valid && config_word.mode == pmw_pkg::MODE_WAKE)
    else $error("link driven outside wake mode");
  a_alarm_cause: assert property (
    $rose(link_oe) |-> $past(adc_valid && !input_selector && in_rng))
    else $error("alarm without a pyro sample");
  a_alarm_hold: assert property (
    $fell(link_oe) && config_word.mode == pmw_pkg::MODE_WAKE |-> link_low_q >= 5 * T)
    else $error("alarm dropped without host clear");
  a_blind_gap: assert property (
    $rose(link_oe) |-> pull_q >= ((int'(config_word.blind) + 1) * HALF_S_TICKS - 1) * T)
    else $error("alarm inside blind time");
  a_read_take: assert property (
    adc_valid && config_valid && config_word.mode != pmw_pkg::MODE_WAKE |=> readout.valid)
    else $error("readout missing");
  a_read_cause: assert property (
    readout.valid |-> $past(adc_valid && config_valid && config_word.mode != pmw_pkg::MODE_WAKE))
    else $error("readout without request");
  a_read_idle: assert property (!readout.valid |-> readout.data == 14'h0)
    else $error("readout data not cleared");
  a_sel_toggle: assert property (
    adc_valid && config_valid && config_word.source == pmw_pkg::SRC_TEMP
    && config_word.mode != pmw_pkg::MODE_WAKE |=> input_selector != $past(input_selector))
    else $error("selector did not alternate");
  a_range_flag: assert property (
    adc_valid && config_valid && !input_selector && !in_rng |=> out_of_range)
    else $error("range flag not set");
  a_cfg_latch: assert property ($changed(config_word) |-> pin_low_q >= 20 * T)
    else $error("config changed without load time");
  c_alarm: cover property ($rose(link_oe));
  c_clear: cover property ($fell(link_oe));
  c_range: cover property (readout.valid && out_of_range);
endmodule

bind pmw_top pmw_top_sva #(.HALF_S_TICKS(HALF_S_TICKS), .OSC_DIV(OSC_DIV)) pmw_top_sva_inst (
  .clk_sys(clk_sys), .reset(reset), .config_serial_input(config_serial_input),
  .link_in(link_in), .link_out(link_out), .link_oe(link_oe), .adc_data(adc_data),
  .adc_valid(adc_valid), .input_selector(input_selector), .readout(readout),
  .config_word(config_word), .config_valid(config_valid), .out_of_range(out_of_range)
);

// ---- sim/pmw_host_model.sv ----
`timescale 1ns/1ps
// Host end of the event link wire
module pmw_host_model (
  // Clock
  input  wire logic clk_sys,
  // Host pull-low request
  input  wire logic host_low,
  // Device drive
  input  wire logic link_out,
  input  wire logic link_oe,
  // Resolved wire
  output logic      link_in
);
  logic float_q = 1'b0; // No pull resistor, a released wire wanders
  // Released wire pattern
  always_ff @(posedge clk_sys) begin
    float_q <= ~float_q;
  end
  // Host low wins; kept low while configuring
  assign link_in = host_low ? 1'b0 : (link_oe ? link_out : float_q);
endmodule

// ---- sim/test_pyro_motion_wakeup_unit.sv ----
`timescale 1ns/1ps
// Host drives config pin, converter samples and link pull-low
module test_pyro_motion_wakeup_unit;
  localparam int T = 40; // Clocks per tick, shortened to keep the run brief
  // Least spacing of readouts: 2 ms of oscillator ticks
  localparam int READ_GAP = (2 * pmw_pkg::OSC_HZ / 1000) * T;
  logic                    clk_sys = 1'b0;
  logic                    reset = 1'b1;
  logic                    cfg_pin = 1'b0;
  logic                    host_low = 1'b1;
  logic                    adc_valid = 1'b0;
  logic [13:0]             adc_data = 14'h2000;
  logic                    link_in, link_out, link_oe, input_selector;
  logic                    config_valid, out_of_range;
  pmw_pkg::pmw_sample_type readout;
  pmw_pkg::pmw_cfg_type    config_word;
  pmw_pkg::pmw_cfg_type    cfg;
  int                      n_mismatch = 0;
  int                      total_checks = 0;
  logic [13:0]             oor_v [4] = '{14'h0100, 14'h3e02, 14'h3e01, 14'h01ff};
  logic                    oor_e [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  always #10 clk_sys = ~clk_sys;

  pmw_top #(.HALF_S_TICKS(4), .OSC_DIV(T)) pmw_top_inst (
    .clk_sys(clk_sys), .reset(reset), .config_serial_input(cfg_pin),
    .link_in(link_in), .link_out(link_out), .link_oe(link_oe),
    .adc_data(adc_data), .adc_valid(adc_valid), .input_selector(input_selector),
    .readout(readout), .config_word(config_word), .config_valid(config_valid),
    .out_of_range(out_of_range)
  );
  pmw_host_model pmw_host_model_inst (
    .clk_sys(clk_sys), .host_low(host_low), .link_out(link_out),
    .link_oe(link_oe), .link_in(link_in)
  );

  // Compare and count
  task automatic check(string what, logic [24:0] seen, logic [24:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Rising edges, drives follow by non-blocking assignment
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Edges, then settle at the falling edge for a look
  task automatic hold(int n);
    tick(n);
    @(negedge clk_sys);
  endtask
  // Word MSB first: rise, apply bit within the hold and keep it past, then low
  task automatic send_cfg(pmw_pkg::pmw_cfg_type c);
    tick(1);
    for (int i = 24; i >= 0; i--) begin
      cfg_pin <= 1'b1;
      tick(20);
      cfg_pin <= c[i];
      tick(3 * T + 20);
      cfg_pin <= 1'b0;
      tick(20);
    end
    hold(22 * T);
  endtask
  // One conversion, readout looked at the cycle after
  task automatic sample(logic [13:0] v, logic ev);
    if (ev) begin
      tick(READ_GAP);
    end
    @(posedge clk_sys);
    adc_data <= v;
    adc_valid <= 1'b1;
    @(posedge clk_sys);
    adc_valid <= 1'b0;
    @(negedge clk_sys);
    check("rd_valid", readout.valid, ev);
  endtask
  // Verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    tick(4);
    reset <= 1'b0;
    hold(10);
    check("cfg_valid", config_valid, 1'b0);
    sample(14'h2000, 1'b0);
    cfg = '{8'h02, 4'h3, 2'h1, 2'h0, pmw_pkg::MODE_FORCED, pmw_pkg::SRC_TEMP,
            2'h2, 1'b0, 1'b0, 1'b1};
    send_cfg(cfg);
    check("cfg_word", config_word, cfg);
    check("cfg_valid", config_valid, 1'b1);
    sample(14'h2000, 1'b1);
    check("sel", input_selector, 1'b1);
    sample(14'h1234, 1'b1);
    check("sel", input_selector, 1'b0);
    sample(14'h2000, 1'b1);
    check("temp", readout.data, 14'h1234);
    for (int i = 0; i < 4; i++) begin
      sample(14'h0abc, 1'b1);
      sample(oor_v[i], 1'b1);
      check("range", out_of_range, oor_e[i]);
    end
    sample(14'h0abc, 1'b1);
    cfg.mode = pmw_pkg::MODE_WAKE;
    cfg.source = pmw_pkg::SRC_BAND;
    send_cfg(cfg);
    tick(1);
    host_low <= 1'b0;
    sample(14'h3400, 1'b0);
    check("alarm", link_oe, 1'b0);
    sample(14'h0c00, 1'b0);
    check("alarm", link_oe, 1'b1);
    hold(3 * T);
    check("alarm", link_oe, 1'b1);
    check("link", link_in, 1'b1);
    tick(1);
    host_low <= 1'b1;
    tick(3 * T);
    host_low <= 1'b0;
    hold(20);
    check("alarm", link_oe, 1'b1);
    tick(1);
    host_low <= 1'b1;
    hold(4 * T);
    check("alarm", link_oe, 1'b1);
    hold(3 * T + 20);
    check("alarm", link_oe, 1'b0);
    tick(1);
    host_low <= 1'b0;
    sample(14'h3400, 1'b0);
    sample(14'h0c00, 1'b0);
    check("alarm", link_oe, 1'b0);
    tick(11 * T);
    sample(14'h3400, 1'b0);
    check("alarm", link_oe, 1'b0);
    sample(14'h0c00, 1'b0);
    check("alarm", link_oe, 1'b1);
    report_and_stop();
  end
endmodule
